// file: bench/scfg_bank_sva.sv
// Checker on the configuration bank's pins.
// Bound to scfg_bank; host keeps sclk halves of 8 clocks.
`timescale 1ns/1ps
`default_nettype none
module scfg_bank_sva #(
  parameter integer RESET_CYC = 75
) (
  input wire logic clock_i, // Device clock
  input wire logic reset_n_i, // Reset, active low
  input wire logic sclk_i, // Serial clock
  input wire logic cs_n_i, // Select, active low
  input wire logic sdo_o, // Serial out
  input wire logic chip_reset_o, // Soft reset busy
  input wire logic [1:0] op_mode_o, // Mode field
  input wire logic power_down_o // Power-down flag
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] busy_reg;
  always_ff @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i) busy_reg <= 8'h00;
    else busy_reg <= chip_reset_o ? busy_reg + 8'h01 : 8'h00;
  mode_pd_a: assert property ((op_mode_o == 2'h3) [*2]
    |-> power_down_o)
    else $error("power-down flag missing");
  mode_norm_a: assert property ((op_mode_o == 2'h0) [*2]
    |-> !power_down_o)
    else $error("power-down flag in normal mode");
  sdo_idle_a: assert property (cs_n_i [*5] |-> !sdo_o)
    else $error("serial out busy while idle");
  sdo_sel_a: assert property ($rose(sdo_o) |-> !$past(cs_n_i, 3))
    else $error("serial out rose outside a frame");
  sdo_fall_a: assert property ($changed(sdo_o) && !cs_n_i
    |-> !sclk_i)
    else $error("serial out moved while clock high");
  mode_frame_a: assert property ($changed(op_mode_o)
    |-> !$past(cs_n_i, 4))
    else $error("mode changed without a frame");
  srst_frame_a: assert property ($rose(chip_reset_o)
    |-> !$past(cs_n_i, 2))
    else $error("soft reset without a frame");
  srst_len_a: assert property ($fell(chip_reset_o)
    |-> busy_reg == RESET_CYC + 1)
    else $error("soft reset length wrong");
  srst_clear_a: assert property (chip_reset_o [*3]
    |-> op_mode_o == 2'h0 && !power_down_o)
    else $error("mode kept through soft reset");
endmodule // scfg_bank_sva
bind scfg_bank scfg_bank_sva #(.RESET_CYC(RESET_CYC)) chk (.clock_i(clock_i),
  .reset_n_i(reset_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .sdo_o(sdo_o),
  .chip_reset_o(chip_reset_o), .op_mode_o(op_mode_o),
  .power_down_o(power_down_o));
`default_nettype wire

// file: bench/scfg_bank_tb.sv
// Self-checking bench for scfg_bank against a register model.
// Assumes scfg_host and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module scfg_bank_tb;
  localparam logic [3:0] CLS = 4'h9; // Arbitrary value
  localparam logic [15:0] FAM = 16'h5a17; // Arbitrary value
  localparam logic [15:0] MKR = 16'h3c61; // Arbitrary value
  logic clock_i, reset_n_i, sclk, cs_n, sdi, sdo, busy, pd;
  logic [1:0] mode;
  logic [7:0] r;
  logic [7:0] m[32];
  int err_count, n_tests, cyc;
  scfg_bank #(.PART_CLASS(CLS), .FAMILY_CODE(FAM), .MAKER_CODE(MKR)) uut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .sdi_i(sdi), .sdo_o(sdo), .chip_reset_o(busy), .op_mode_o(mode),
    .power_down_o(pd));
  scfg_host host (.clock_i(clock_i), .sclk_o(sclk), .cs_n_o(cs_n),
    .sdi_o(sdi), .sdo_i(sdo));
  function automatic void m_reset();
    m = '{default: 8'h00};
    m[0] = 8'h30;
    m[3] = {4'h0, CLS};
    {m[5], m[4]} = FAM;
    {m[13], m[12]} = MKR;
  endfunction
  function automatic void m_wr(int a, logic [7:0] d);
    if (a == 0 && d[7]) m_reset();
    else if (a == 0) m[0] = d | 8'h10;
    else if (a == 2 || a == 16) m[a] = d;
    else if (a == 3) m[3] = {d[7:4], CLS};
  endfunction
  function automatic int nxt(int a);
    return m[16][0] ? a : (m[0][5] ? a + 1 : a - 1);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int a, input logic [7:0] q[$]);
    host.tx_q = q;
    host.frame(1'b0, a[14:0], q.size());
    foreach (q[i]) begin
      m_wr(a, q[i]);
      a = nxt(a);
    end
  endtask
  task automatic rd(input int a, input int n);
    host.rx_q.delete();
    host.frame(1'b1, a[14:0], n);
    for (int i = 0; i < n; i++) begin
      chk(host.rx_q[i], m[a]);
      a = nxt(a);
    end
  endtask
  task automatic stop_test();
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    reset_n_i = 1'b0;
    err_count = 0;
    n_tests = 0;
    cyc = 0;
    r = 8'($urandom(75820));
    m_reset();
    repeat (3) @(posedge clock_i);
    #1 reset_n_i = 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    rd(0, 6);
    rd(12, 2);
    rd(16, 1);
    wr(0, '{r & 8'h7f | 8'h20});
    rd(0, 1);
    r = 8'($urandom);
    wr(2, '{r | 8'h03, 8'hff, 8'h11, 8'h22}); // Mode code 3 only
    rd(2, 4);
    chk({5'h00, pd, mode}, 8'h07);
    wr(0, '{8'h10});
    wr(3, '{8'h0a, r & 8'hfc});
    rd(3, 2);
    chk({5'h00, pd, mode}, 8'h00);
    wr(16, '{8'h01});
    wr(2, '{8'h5c, 8'h7c});
    rd(2, 2);
    wr(2, '{8'h03});
    wr(0, '{8'h80});
    chk({4'h0, busy, pd, mode}, 8'h08);
    #750; // Quiet time after a soft reset
    rd(0, 3);
    rd(16, 1);
    chk({4'h0, busy, pd, mode}, 8'h00);
    stop_test();
  end
endmodule // scfg_bank_tb
`default_nettype wire

// file: bench/scfg_host.sv
// Serial host model: 4-wire frames, clock idle low.
// Times halves of the serial clock in device clocks.
`timescale 1ns/1ps
`default_nettype none
module scfg_host (
  input wire logic clock_i, // Device clock
  output logic sclk_o, // Serial clock
  output logic cs_n_o, // Select, active low
  output logic sdi_o, // Serial data to device
  input wire logic sdo_i // Serial data from device
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  task automatic half();
    repeat (8) @(posedge clock_i);
    #1;
  endtask
  task automatic bitx(input logic b, output logic r);
    sdi_o = b;
    half();
    r = sdo_i; // Read data only from the output line
    sclk_o = 1'b1;
    half();
    sclk_o = 1'b0;
  endtask
  task automatic frame(input logic rd, input logic [14:0] a, input int n);
    logic [15:0] h;
    logic [7:0] d;
    logic r;
    h = {rd, a};
    cs_n_o = 1'b0;
    half();
    for (int i = 15; i >= 0; i--) bitx(h[i], r);
    for (int k = 0; k < n; k++) begin
      d = rd ? 8'h00 : tx_q.pop_front();
      for (int i = 7; i >= 0; i--) bitx(d[i], d[i]);
      if (rd) rx_q.push_back(d);
    end
    half();
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o; // Released line must not look held
    half();
  endtask
endmodule // scfg_host
`default_nettype wire

// file: inc/scfg_map.vh
// Register map, field positions, reset values and timing counts of the
// converter's configuration and identification bank.
// Assumes a 100 MHz device clock; included by the bank's design file.
`ifndef SCFG_MAP_VH
`define SCFG_MAP_VH

`define SCFG_ADDR_W 15
`define SCFG_ADDR_IFCFG 15'h0000
`define SCFG_ADDR_PWRCFG 15'h0002
`define SCFG_ADDR_CLASS 15'h0003
`define SCFG_ADDR_FAMILY_LO 15'h0004
`define SCFG_ADDR_FAMILY_HI 15'h0005
`define SCFG_ADDR_MAKER_LO 15'h000c
`define SCFG_ADDR_MAKER_HI 15'h000d
`define SCFG_ADDR_STREAM 15'h0010

`define SCFG_BIT_SOFT_RESET 7
`define SCFG_BIT_ASCEND 5
`define SCFG_BIT_OUT_LINE 4
`define SCFG_BIT_ADDR_FREEZE 0
`define SCFG_MODE_MSB 1
`define SCFG_MODE_LSB 0
`define SCFG_CLASS_MSB 3

`define SCFG_RST_IFCFG 8'h30
`define SCFG_RST_PWRCFG 8'h00
`define SCFG_RST_CLASS_HI 4'h0
`define SCFG_RST_STREAM 8'h00
`define SCFG_MODE_NORMAL 2'h0
`define SCFG_MODE_POWER_DOWN 2'h3

`define SCFG_HDR_BITS 5'h10
`define SCFG_CLK_PERIOD_NS 10
`define SCFG_SOFT_RESET_NS 750
`define SCFG_SOFT_RESET_CYC \
  ((`SCFG_SOFT_RESET_NS + `SCFG_CLK_PERIOD_NS - 1) / `SCFG_CLK_PERIOD_NS)

`endif

// file: src/scfg_bank.v
// Configuration and identification registers behind a 4-wire serial port.
// Assumes the serial clock is at most one eighth of clock_i; all serial
// pins are oversampled through two flip-flops on clock_i.
//
// Operation
// - Soft reset bit resets whole device, registers
// - Soft reset bit clears itself afterwards
// - Streaming address descends at 0, ascends at 1
// - Output-line flag reads 1; reads on output
// - No three-wire mode; input never drives
// - Mode field: 0 normal, 3 power-down
// - Read-only four-bit part class, reserved upper
// - Read-only sixteen-bit family code, writes ignored
// - Read-only sixteen-bit maker code
// - Address freeze bit holds streaming address
// - Interface configuration reads 0x30 after reset
// - Reserved bits read-write, reset to zero
`timescale 1ns/1ps
`default_nettype none
`include "scfg_map.vh"

module scfg_bank #(
  parameter [3:0] PART_CLASS = 4'h5,      // Arbitrary value
  parameter [15:0] FAMILY_CODE = 16'h00a5, // Arbitrary value
  parameter [15:0] MAKER_CODE = 16'h0c3e,  // Arbitrary value
  parameter integer RESET_CYC = `SCFG_SOFT_RESET_CYC
) (
  input wire clock_i,          // 100 MHz device clock
  input wire reset_n_i,        // Power-on reset, async, active low
  input wire sclk_i,           // Serial clock pin
  input wire cs_n_i,           // Serial chip select pin, active low
  input wire sdi_i,            // Serial data in pin
  output reg sdo_o,            // Serial data out pin
  output reg chip_reset_o,     // High while a soft reset is in progress
  output reg [1:0] op_mode_o,  // Operating mode field
  output reg power_down_o      // High in power-down mode
);

  // Pin synchronisers: stage one is only read by stage two
  reg [2:0] sclk_reg;
  reg [2:0] csn_reg;
  reg [1:0] sdi_reg;
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_reg <= 3'h0;
      csn_reg <= 3'h7;
      sdi_reg <= 2'h0;
    end else begin
      sclk_reg <= {sclk_reg[1:0], sclk_i};
      csn_reg <= {csn_reg[1:0], cs_n_i};
      sdi_reg <= {sdi_reg[0], sdi_i};
    end
  end

  wire sclk_rise = sclk_reg[1] & ~sclk_reg[2];
  wire sclk_fall = ~sclk_reg[1] & sclk_reg[2];
  wire cs_fall = ~csn_reg[1] & csn_reg[2];
  wire cs_high = csn_reg[1];
  wire sdi_s = sdi_reg[1];

  // Registers
  reg [7:0] ifcfg_reg;
  reg [7:0] pwrcfg_reg;
  reg [3:0] class_hi_reg;
  reg [7:0] stream_reg;

  // Frame state
  reg active_reg;
  reg rd_reg;
  reg [4:0] hdr_cnt_reg;
  reg [2:0] bit_cnt_reg;
  reg [14:0] addr_reg;
  reg [7:0] shift_reg;
  reg [7:0] sdo_sh_reg;
  reg [7:0] rst_cnt_reg;

  wire busy = (rst_cnt_reg != 8'h00);
  wire in_data = (hdr_cnt_reg == `SCFG_HDR_BITS);

  // Read mux, soft reset bit always reads back zero
  reg [7:0] rd_data;
  always @* begin
    rd_data = 8'h00;
    case (addr_reg)
      `SCFG_ADDR_IFCFG: begin
        rd_data = ifcfg_reg;
        rd_data[`SCFG_BIT_SOFT_RESET] = 1'b0;
        rd_data[`SCFG_BIT_OUT_LINE] = 1'b1;
      end
      `SCFG_ADDR_PWRCFG: rd_data = pwrcfg_reg;
      `SCFG_ADDR_CLASS: rd_data = {class_hi_reg, PART_CLASS};
      `SCFG_ADDR_FAMILY_LO: rd_data = FAMILY_CODE[7:0];
      `SCFG_ADDR_FAMILY_HI: rd_data = FAMILY_CODE[15:8];
      `SCFG_ADDR_MAKER_LO: rd_data = MAKER_CODE[7:0];
      `SCFG_ADDR_MAKER_HI: rd_data = MAKER_CODE[15:8];
      `SCFG_ADDR_STREAM: rd_data = stream_reg;
      default: rd_data = 8'h00;
    endcase
  end

  // Next address after each data byte
  reg [14:0] addr_next;
  always @* begin
    if (stream_reg[`SCFG_BIT_ADDR_FREEZE])
      addr_next = addr_reg;
    else if (ifcfg_reg[`SCFG_BIT_ASCEND])
      addr_next = addr_reg + 15'h0001;
    else
      addr_next = addr_reg - 15'h0001;
  end

  wire [7:0] wr_byte = {shift_reg[6:0], sdi_s};
  wire byte_done = active_reg & in_data & sclk_rise & (bit_cnt_reg == 3'h7);
  wire wr_en = byte_done & ~rd_reg;
  wire soft_req = wr_en & (addr_reg == `SCFG_ADDR_IFCFG) &
                  wr_byte[`SCFG_BIT_SOFT_RESET];

  // Register file; soft reset returns every field to its default
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ifcfg_reg <= `SCFG_RST_IFCFG;
      pwrcfg_reg <= `SCFG_RST_PWRCFG;
      class_hi_reg <= `SCFG_RST_CLASS_HI;
      stream_reg <= `SCFG_RST_STREAM;
      rst_cnt_reg <= 8'h00;
    end else if (soft_req) begin
      ifcfg_reg <= `SCFG_RST_IFCFG;
      pwrcfg_reg <= `SCFG_RST_PWRCFG;
      class_hi_reg <= `SCFG_RST_CLASS_HI;
      stream_reg <= `SCFG_RST_STREAM;
      rst_cnt_reg <= RESET_CYC[7:0];
    end else if (busy) begin
      rst_cnt_reg <= rst_cnt_reg - 8'h01;
    end else if (wr_en) begin
      case (addr_reg)
        `SCFG_ADDR_IFCFG: begin
          ifcfg_reg <= {1'b0, wr_byte[6:5], 1'b1, wr_byte[3:0]};
        end
        `SCFG_ADDR_PWRCFG: pwrcfg_reg <= wr_byte;
        `SCFG_ADDR_CLASS: class_hi_reg <= wr_byte[7:4];
        `SCFG_ADDR_STREAM: stream_reg <= wr_byte;
        default: ;
      endcase
    end
  end

  // Serial frame engine: 1 read flag, 15 address bits, then data bytes
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      active_reg <= 1'b0;
      rd_reg <= 1'b0;
      hdr_cnt_reg <= 5'h00;
      bit_cnt_reg <= 3'h0;
      addr_reg <= 15'h0000;
      shift_reg <= 8'h00;
      sdo_sh_reg <= 8'h00;
    end else if (busy || soft_req || cs_high) begin
      // A frame running into a soft reset is dropped until cs rises
      active_reg <= 1'b0;
      hdr_cnt_reg <= 5'h00;
      bit_cnt_reg <= 3'h0;
      sdo_sh_reg <= 8'h00;
    end else if (cs_fall) begin
      active_reg <= 1'b1;
      hdr_cnt_reg <= 5'h00;
      bit_cnt_reg <= 3'h0;
    end else if (active_reg) begin
      if (sclk_rise) begin
        shift_reg <= wr_byte;
        if (!in_data) begin
          hdr_cnt_reg <= hdr_cnt_reg + 5'h01;
          if (hdr_cnt_reg == 5'h00)
            rd_reg <= sdi_s;
          else
            addr_reg <= {addr_reg[13:0], sdi_s};
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == 3'h7)
            addr_reg <= addr_next;
        end
      end
      if (sclk_fall && in_data && rd_reg) begin
        // Load at each byte start so the address step is seen in time
        if (bit_cnt_reg == 3'h0)
          sdo_sh_reg <= rd_data;
        else
          sdo_sh_reg <= {sdo_sh_reg[6:0], 1'b0};
      end
    end
  end

  // Read data only ever leaves on the dedicated output pin
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sdo_o <= 1'b0;
      chip_reset_o <= 1'b0;
      op_mode_o <= `SCFG_MODE_NORMAL;
      power_down_o <= 1'b0;
    end else begin
      sdo_o <= sdo_sh_reg[7];
      chip_reset_o <= soft_req | busy;
      op_mode_o <= pwrcfg_reg[`SCFG_MODE_MSB:`SCFG_MODE_LSB];
      power_down_o <= (pwrcfg_reg[`SCFG_MODE_MSB:`SCFG_MODE_LSB] ==
                       `SCFG_MODE_POWER_DOWN);
    end
  end

endmodule // scfg_bank
`default_nettype wire
